// ===== design/agc_gain_limit_carrier_sense.sv
// Gain-limit and carrier-sense configuration with a step-wise gain decision loop.
// Assumes a register port driven by the host interface logic on the same clock
// and averaged amplitude samples from the channel filter, also on this clock.
`timescale 1ns/1ps
`default_nettype none
module agc_gain_limit_carrier_sense
#(
  parameter int gain_steps = 8
)
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // register port
  input  wire logic             reg_wr,
  input  wire logic [5:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  output logic      [7:0]       reg_rdata,
  // channel filter amplitude
  input  wire logic             sample_valid,
  input  wire logic [7:0]       sample_db,
  // gain decisions
  output agc_pkg::gain_set_s    gain_set,
  output logic      [2:0]       digital_gain_max,
  output logic      [7:0]       amplifier_drop_tenth_db,
  output logic      [7:0]       amplitude_target_db,
  output logic                  carrier_sense
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  // the tightest amplifier cap takes 7 combined steps off 2*(gain_steps-1);
  // with fewer than 5 steps that ceiling would wrap and stop limiting at all
  if (gain_steps < 5 || gain_steps > 8)
  begin : g_bad_steps
    $error("gain_steps must lie in 5..8");
  end

  localparam logic [2:0] top_step = 3'(gain_steps - 1);

  typedef struct packed {
    logic [7:0]         ceiling_target;
    logic [7:0]         order_sense;
    logic [7:0]         rdata;
    agc_pkg::gain_set_s gains;
    logic [2:0]         dig_max;
    logic [7:0]         amp_drop;
    logic [7:0]         target_db;
  } top_state_s;

  top_state_s        state_ff;
  top_state_s        nxt_state;
  agc_pkg::agc_cfg_s cfg;
  logic [3:0]        amp_sum;
  logic [3:0]        amp_limit;
  logic              above;
  logic              below;

  // ----------------------------------------------------------------
  // field split
  // ----------------------------------------------------------------
  always_comb
  begin
    cfg.digital_gain_cap         = state_ff.ceiling_target[agc_pkg::digital_cap_lsb +: 2];
    cfg.amplifier_gain_cap       = state_ff.ceiling_target[agc_pkg::amplifier_cap_lsb +: 3];
    cfg.amplitude_target         = state_ff.ceiling_target[agc_pkg::target_lsb +: 3];
    cfg.gain_reduction_order     = state_ff.order_sense[agc_pkg::order_bit];
    cfg.relative_sense_threshold = state_ff.order_sense[agc_pkg::rel_thr_lsb +: 2];
    cfg.absolute_sense_threshold = state_ff.order_sense[agc_pkg::abs_thr_lsb +: 4];
  end

  // combined amplifier index, each code lowers the ceiling by one step
  always_comb
  begin
    amp_sum   = {1'b0, state_ff.gains.amp1_gain} + {1'b0, state_ff.gains.amp2_gain};
    amp_limit = 4'({top_step, 1'b0}) - {1'b0, cfg.amplifier_gain_cap};
    above     = sample_db > state_ff.target_db;
    below     = sample_db < state_ff.target_db;
  end

  // ----------------------------------------------------------------
  // register writes, reads and gain loop
  // ----------------------------------------------------------------
  // reduction goes analog first in the chosen order, then digital; raising
  // fills digital first so the front end keeps its best noise figure
  always_comb
  begin
    nxt_state = state_ff;
    if (reg_wr && reg_addr == agc_pkg::ceiling_target_addr)
      nxt_state.ceiling_target = reg_wdata;
    if (reg_wr && reg_addr == agc_pkg::order_sense_addr)
      nxt_state.order_sense = reg_wdata & agc_pkg::order_sense_mask;
    unique case (reg_addr)
      agc_pkg::ceiling_target_addr: nxt_state.rdata = state_ff.ceiling_target;
      agc_pkg::order_sense_addr:    nxt_state.rdata = state_ff.order_sense;
      default:                      nxt_state.rdata = 8'h00;
    endcase
    nxt_state.dig_max   = top_step - {1'b0, cfg.digital_gain_cap};
    nxt_state.amp_drop  = agc_pkg::amp_drop_tab[cfg.amplifier_gain_cap];
    nxt_state.target_db = agc_pkg::target_db_tab[cfg.amplitude_target];
    // a lowered cap clamps the digital gain in a single step and steps the amplifiers down one code per cycle
    if (state_ff.gains.digital_gain > state_ff.dig_max)
      nxt_state.gains.digital_gain = state_ff.dig_max;
    else if (amp_sum > amp_limit)
    begin
      if (cfg.gain_reduction_order && state_ff.gains.amp1_gain != 3'h0)
        nxt_state.gains.amp1_gain = state_ff.gains.amp1_gain - 3'h1;
      else if (state_ff.gains.amp2_gain != 3'h0)
        nxt_state.gains.amp2_gain = state_ff.gains.amp2_gain - 3'h1;
      else
        nxt_state.gains.amp1_gain = state_ff.gains.amp1_gain - 3'h1;
    end
    else if (sample_valid && above)
    begin
      if (cfg.gain_reduction_order && state_ff.gains.amp1_gain != 3'h0)
        nxt_state.gains.amp1_gain = state_ff.gains.amp1_gain - 3'h1;
      else if (state_ff.gains.amp2_gain != 3'h0)
        nxt_state.gains.amp2_gain = state_ff.gains.amp2_gain - 3'h1;
      else if (state_ff.gains.amp1_gain != 3'h0)
        nxt_state.gains.amp1_gain = state_ff.gains.amp1_gain - 3'h1;
      else if (state_ff.gains.digital_gain != 3'h0)
        nxt_state.gains.digital_gain = state_ff.gains.digital_gain - 3'h1;
    end
    else if (sample_valid && below)
    begin
      if (state_ff.gains.digital_gain < state_ff.dig_max)
        nxt_state.gains.digital_gain = state_ff.gains.digital_gain + 3'h1;
      else if (amp_sum < amp_limit && state_ff.gains.amp2_gain < top_step)
        nxt_state.gains.amp2_gain = state_ff.gains.amp2_gain + 3'h1;
      else if (amp_sum < amp_limit && state_ff.gains.amp1_gain < top_step)
        nxt_state.gains.amp1_gain = state_ff.gains.amp1_gain + 3'h1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_ff.ceiling_target <= agc_pkg::ceiling_target_rst;
      state_ff.order_sense    <= agc_pkg::order_sense_rst;
      state_ff.rdata          <= 8'h00;
      state_ff.gains          <= '0;
      state_ff.dig_max        <= 3'h0;
      state_ff.amp_drop       <= 8'h00;
      state_ff.target_db      <= 8'h00;
    end
    else
      state_ff <= nxt_state;
  end

  // ----------------------------------------------------------------
  // carrier sense
  // ----------------------------------------------------------------
  carrier_sense u_sense
  (
    .clk                      (clk),
    .rst                      (rst),
    .sample_valid             (sample_valid),
    .sample_db                (sample_db),
    .target_db                (state_ff.target_db),
    .relative_sense_threshold (cfg.relative_sense_threshold),
    .absolute_sense_threshold (cfg.absolute_sense_threshold),
    .carrier_sense            (carrier_sense)
  );

  assign reg_rdata               = state_ff.rdata;
  assign gain_set                = state_ff.gains;
  assign digital_gain_max        = state_ff.dig_max;
  assign amplifier_drop_tenth_db = state_ff.amp_drop;
  assign amplitude_target_db     = state_ff.target_db;

endmodule : agc_gain_limit_carrier_sense
`default_nettype wire

// ===== design/agc_pkg.sv
// Constants, register map and carriers for the gain-limit and carrier-sense block.
// Assumes a single 125 MHz core clock and a synchronous active-high reset.
package agc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [5:0] ceiling_target_addr = 6'h1b;
  localparam logic [5:0] order_sense_addr    = 6'h1c;
  localparam logic [7:0] ceiling_target_rst  = 8'h03;
  localparam logic [7:0] order_sense_rst     = 8'h40;
  localparam logic [7:0] order_sense_mask    = 8'h7f;  // bit 7 reads zero

  // field positions
  localparam int digital_cap_lsb   = 6;
  localparam int amplifier_cap_lsb = 3;
  localparam int target_lsb        = 0;
  localparam int order_bit         = 6;
  localparam int rel_thr_lsb       = 4;
  localparam int abs_thr_lsb       = 0;

  // ----------------------------------------------------------------
  // decode tables
  // ----------------------------------------------------------------
  // amplitude target in dB per code
  localparam logic [7:0] target_db_tab [8] = '{8'h18, 8'h1b, 8'h1e, 8'h21,
                                               8'h24, 8'h26, 8'h28, 8'h2a};
  // amplifier ceiling drop in tenths of a dB per code
  localparam logic [7:0] amp_drop_tab [8] = '{8'h00, 8'h1a, 8'h3d, 8'h4a,
                                              8'h5c, 8'h73, 8'h92, 8'hab};
  // relative rise in dB per code, code 0 unused
  localparam logic [7:0] rel_rise_tab [4] = '{8'h00, 8'h06, 8'h0a, 8'h0e};
  localparam logic [3:0] abs_thr_off      = 4'h8;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] digital_gain_cap;
    logic [2:0] amplifier_gain_cap;
    logic [2:0] amplitude_target;
    logic       gain_reduction_order;
    logic [1:0] relative_sense_threshold;
    logic [3:0] absolute_sense_threshold;
  } agc_cfg_s;

  typedef struct packed {
    logic [2:0] amp1_gain;
    logic [2:0] amp2_gain;
    logic [2:0] digital_gain;
  } gain_set_s;

endpackage : agc_pkg

// ===== design/carrier_sense.sv
// Carrier-sense decision from RSSI samples.
// Assumes samples and settings come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module carrier_sense
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // rssi samples
  input  wire logic       sample_valid,
  input  wire logic [7:0] sample_db,
  // settings
  input  wire logic [7:0] target_db,
  input  wire logic [1:0] relative_sense_threshold,
  input  wire logic [3:0] absolute_sense_threshold,
  // decision
  output logic            carrier_sense
);

  typedef struct packed {
    logic [7:0] baseline;
    logic       cs;
  } cs_state_s;

  cs_state_s state_ff;
  cs_state_s nxt_state;
  logic signed [9:0] abs_level;
  logic [8:0]        rel_level;
  logic              abs_hit;
  logic              rel_hit;

  // threshold arithmetic, signed code offsets the target by whole dB
  always_comb
  begin
    abs_level = $signed({2'b00, target_db}) +
                $signed({{6{absolute_sense_threshold[3]}}, absolute_sense_threshold});
    rel_level = {1'b0, state_ff.baseline} +
                {1'b0, agc_pkg::rel_rise_tab[relative_sense_threshold]};
    abs_hit   = (absolute_sense_threshold != agc_pkg::abs_thr_off) &&
                ($signed({2'b00, sample_db}) >= abs_level);
    rel_hit   = (relative_sense_threshold != 2'b00) &&
                ({1'b0, sample_db} >= rel_level);
  end

  // the baseline tracks the floor only while idle, so a slow rise is not sensed
  always_comb
  begin
    nxt_state = state_ff;
    if (sample_valid)
    begin
      nxt_state.cs = abs_hit | rel_hit;
      if (!(abs_hit | rel_hit))
        nxt_state.baseline = sample_db;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      state_ff <= '0;
    else
      state_ff <= nxt_state;
  end

  assign carrier_sense = state_ff.cs;

endmodule : carrier_sense
`default_nettype wire

// ===== test/agc_gain_limit_carrier_sense_tb.sv
// testbench: register port, gain stepping and carrier-sense decisions
// assumes the bound checker and the default gain_steps of 8
`timescale 1ns/1ps
`default_nettype none
module agc_gain_limit_carrier_sense_tb;
  logic               clk, rst, reg_wr, sample_valid, cs;
  logic [5:0]         reg_addr;
  logic [7:0]         reg_wdata, reg_rdata, sample_db, drop_w, tgt_w;
  logic [2:0]         max_w;
  agc_pkg::gain_set_s gains;
  int                 fail_count = 0;
  int                 total_checks = 0;
  logic [7:0]         tgt_tab [8] = '{8'h18, 8'h1b, 8'h1e, 8'h21, 8'h24, 8'h26, 8'h28, 8'h2a};
  logic [7:0]         drop_tab [8] = '{8'h00, 8'h1a, 8'h3d, 8'h4a, 8'h5c, 8'h73, 8'h92, 8'hab};

  agc_gain_limit_carrier_sense u_dut (
    .clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .sample_valid(sample_valid), .sample_db(sample_db),
    .gain_set(gains), .digital_gain_max(max_w), .amplifier_drop_tenth_db(drop_w),
    .amplitude_target_db(tgt_w), .carrier_sense(cs));

  // every compare is counted, a mismatch prints at once
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // write strobe stands for exactly one edge
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk) #1;
    reg_wr = 1'b0;
  endtask : wr

  // read data is registered, so it is looked at one edge after the address
  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    @(posedge clk) #1;
    reg_addr = a;
    @(posedge clk) #1;
    chk("reg_rdata", exp, reg_rdata);
  endtask : rd

  // one sample pulse; the decision lands on the edge that takes it
  task automatic smp(input logic [7:0] db, input logic exp);
    @(posedge clk) #1;
    sample_valid = 1'b1;
    sample_db = db;
    @(posedge clk) #1;
    sample_valid = 1'b0;
    chk("carrier_sense", {7'h00, exp}, {7'h00, cs});
  endtask : smp

  task automatic final_report;
    if (fail_count == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report

  // 125 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // the tests need well under a thousand cycles; a hang counts as a mismatch
  initial
  begin
    repeat (5000) @(posedge clk);
    fail_count++;
    final_report();
  end

  // main sequence
  initial
  begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_addr = 6'h00;
    reg_wdata = 8'h00;
    sample_valid = 1'b0;
    sample_db = 8'h00;
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    rd(6'h1b, 8'h03);
    rd(6'h1c, 8'h40);
    chk("amplitude_target_db", 8'h21, tgt_w);
    // every cap and target code, read back and decoded
    for (int i = 0; i < 8; i++)
    begin
      wr(6'h1b, {i[1:0], i[2:0], i[2:0]});
      rd(6'h1b, {i[1:0], i[2:0], i[2:0]});
      chk("digital_gain_max", 8'h07 - 8'(i[1:0]), {5'h00, max_w});
      chk("amplifier_drop_tenth_db", drop_tab[i], drop_w);
      chk("amplitude_target_db", tgt_tab[i], tgt_w);
    end
    // unused bit reads zero and an unmapped write changes nothing
    wr(6'h1c, 8'hff);
    wr(6'h1a, 8'h55);
    rd(6'h1a, 8'h00);
    rd(6'h1c, 8'h7f);
    // climb to full gain, then one step down under each order setting
    wr(6'h1c, 8'h40);
    wr(6'h1b, 8'h03);
    repeat (24) smp(8'h00, 1'b0);
    chk("digital_gain", 8'h07, {5'h00, gains.digital_gain});
    chk("amp2_gain", 8'h07, {5'h00, gains.amp2_gain});
    smp(8'h30, 1'b1);
    chk("amp1_gain", 8'h06, {5'h00, gains.amp1_gain});
    wr(6'h1c, 8'h00);
    smp(8'h30, 1'b1);
    chk("amp2_gain", 8'h06, {5'h00, gains.amp2_gain});
    chk("amp1_gain", 8'h06, {5'h00, gains.amp1_gain});
    // tightest caps pull the gains down with no sample at all
    wr(6'h1b, 8'hfb);
    repeat (8) @(posedge clk);
    #1;
    chk("digital_gain", 8'h04, {5'h00, gains.digital_gain});
    chk("amp_gain_sum", 8'h07, 8'(gains.amp1_gain) + 8'(gains.amp2_gain));
    // each absolute code just below and at its threshold, code 8 is off
    for (int k = 0; k < 16; k++)
    begin
      wr(6'h1c, 8'(k));
      smp(8'h20 + {{4{k[3]}}, k[3:0]}, 1'b0);
      smp(8'h21 + {{4{k[3]}}, k[3:0]}, k != 8);
    end
    // relative rise codes with the absolute criterion off
    for (int r = 1; r < 4; r++)
    begin
      wr(6'h1c, {2'b00, r[1:0], 4'h8});
      smp(8'h14, 1'b0);
      smp(8'h14 + 8'(4 * r + 2), 1'b1);
      smp(8'h13 + 8'(4 * r + 2), 1'b0);
    end
    // a hit, then a second reset in mid-run: settings and decisions return to idle
    smp(8'hff, 1'b1);
    rst = 1'b1;
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    chk("carrier_sense", 8'h00, {7'h00, cs});
    chk("amp1_gain", 8'h00, {5'h00, gains.amp1_gain});
    chk("amp2_digital_gain", 8'h00, {2'b00, gains.amp2_gain, gains.digital_gain});
    rd(6'h1b, 8'h03);
    rd(6'h1c, 8'h40);
    chk("digital_gain_max", 8'h07, {5'h00, max_w});
    final_report();
  end
endmodule : agc_gain_limit_carrier_sense_tb
`default_nettype wire

// ===== test/agc_props.sv
// checker: port relations of the gain-limit and carrier-sense block
// assumes it is bound onto that block and shares its single clock
`timescale 1ns/1ps
`default_nettype none
module agc_props
#(
  parameter int gain_steps = 8
)
(
  // clock, reset and register port
  input wire logic               clk,
  input wire logic               rst,
  input wire logic               reg_wr,
  input wire logic [5:0]         reg_addr,
  input wire logic [7:0]         reg_wdata,
  input wire logic [7:0]         reg_rdata,
  // samples and decisions
  input wire logic               sample_valid,
  input wire logic [7:0]         sample_db,
  input wire agc_pkg::gain_set_s gain_set,
  input wire logic [2:0]         digital_gain_max,
  input wire logic [7:0]         amplifier_drop_tenth_db,
  input wire logic [7:0]         amplitude_target_db,
  input wire logic               carrier_sense
);
  logic [7:0] cs_ff;
  logic       abs_hit;
  // shadow of the sense register, since the ports show the settings only when it is read
  always_ff @(posedge clk)
  begin
    cs_ff <= rst ? 8'h40 : (reg_wr && reg_addr == 6'h1c) ? reg_wdata : cs_ff;
  end
  // absolute level reached; the decision uses the registered target, so a sample
  // right after a target write is still judged against the old target
  assign abs_hit = int'(sample_db) >= int'(amplitude_target_db)
                   + int'($signed(cs_ff[3:0]));
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // a write that is not overwritten in the next cycle
  sequence cap_write;
    reg_wr && reg_addr == 6'h1b ##1 !(reg_wr && reg_addr == 6'h1b);
  endsequence
  a_cap_sets_max: assert property (cap_write |=>
    digital_gain_max == 3'(gain_steps - 1 - int'($past(reg_wdata[7:6], 2)))) else $error("max");
  a_digital_capped: assert property ($stable(digital_gain_max) |->
    gain_set.digital_gain <= digital_gain_max) else $error("digital gain above cap");
  a_drop_decode: assert property (cap_write |=>
    amplifier_drop_tenth_db == agc_pkg::amp_drop_tab[$past(reg_wdata[5:3], 2)]) else $error("drop");
  a_target_decode: assert property (cap_write |=>
    amplitude_target_db == agc_pkg::target_db_tab[$past(reg_wdata[2:0], 2)]) else $error("target");
  a_one_amp_step: assert property ($onehot0({gain_set.amp1_gain != $past(gain_set.amp1_gain),
    gain_set.amp2_gain != $past(gain_set.amp2_gain)})) else $error("two amplifiers moved");
  a_unused_bit_zero: assert property (reg_addr == 6'h1c |=> !reg_rdata[7])
    else $error("unused bit set");
  a_abs_threshold: assert property (sample_valid && cs_ff[5:4] == 2'h0 && cs_ff[3:0] != 4'h8
    |=> carrier_sense == $past(abs_hit)) else $error("absolute threshold");
  a_both_off_quiet: assert property (sample_valid && cs_ff[5:0] == 6'h08
    |=> !carrier_sense) else $error("sense with both criteria off");
  c_sense: cover property (sample_valid ##1 carrier_sense);
  c_clamp: cover property (gain_set.digital_gain > digital_gain_max);
  c_full: cover property (gain_set.amp1_gain == 3'h7 && gain_set.amp2_gain == 3'h7);
endmodule : agc_props
bind agc_gain_limit_carrier_sense agc_props #(.gain_steps(gain_steps)) u_props (
  .clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .sample_valid(sample_valid), .sample_db(sample_db),
  .gain_set(gain_set), .digital_gain_max(digital_gain_max),
  .amplifier_drop_tenth_db(amplifier_drop_tenth_db),
  .amplitude_target_db(amplitude_target_db), .carrier_sense(carrier_sense));
`default_nettype wire
